// ==== bench/e3_rx_overhead_serial_out_bench.sv ====
// Purpose: Self-checking bench for the overhead serial port
// Assumes: Inputs driven on the falling mclk edge
// Notes:   Expected bytes queued at push, compared at recovery
`timescale 1ns/1ps
`default_nettype none
module e3_rx_overhead_serial_out_bench;
	logic        mclk = 1'b0;
	logic        rst_b = 1'b0;
	logic [7:0]  ohByte = 8'h00;
	logic        ohFirst = 1'b0;
	logic        ohValid = 1'b0;
	wire         ohReady, ohClk, ohData, ohMark, frameActive, underrun, resync, byteTick;
	wire  [7:0]  byteData;
	wire  [2:0]  byteNum;
	int          checks = 0;
	int          failures = 0;
	int          fullSeen = 0;
	int          abortSeen = 0;
	int          restartSeen = 0;
	int          seedTmp;
	logic [10:0] expQ[$];
	logic [7:0]  fr;
	always #10 mclk = ~mclk;
	e3_rx_overhead_serial_out DUT (.mclk(mclk), .rst_b(rst_b), .ohByte(ohByte),
		.ohFirst(ohFirst), .ohValid(ohValid), .ohReady(ohReady),
		.overheadBitClockOut(ohClk), .rxOverheadSerialOut(ohData),
		.overheadFrameMarker(ohMark), .frameActive(frameActive),
		.underrun(underrun), .resync(resync));
	oh_terminal_model TERM (.ohClk(ohClk), .ohData(ohData), .ohMark(ohMark),
		.byteData(byteData), .byteNum(byteNum), .byteTick(byteTick));
	// Note refusals and status pulses
	always @(negedge mclk) begin
		fullSeen += (ohReady === 1'b0);
		abortSeen += (underrun === 1'b1);
		restartSeen += (resync === 1'b1);
	end
	// Compare each recovered byte with the oldest note
	always @(byteTick) begin
		if (rst_b) begin
			checks++;
			if (expQ.size() == 0)
				fail("byte with nothing noted");
			else if ({byteNum, byteData} !== expQ.pop_front())
				fail("wrong byte recovered");
		end
	end
	task automatic fail(input string msg);
		failures++;
		$display("unexpected at %0t: %s", $time, msg);
	endtask
	task automatic end_sim();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// One push, held until the buffer accepts it
	task automatic push(input logic [7:0] b, input logic f);
		int k;
		ohByte = b;
		ohFirst = f;
		ohValid = 1'b1;
		for (k = 0; k < 200 && ohReady !== 1'b1; k++) @(negedge mclk);
		if (k == 200) begin
			fail("push stalled");
			end_sim();
		end
		@(posedge mclk);
		@(negedge mclk);
	endtask
	// First n bytes of a random frame; pad notes idle zero bytes
	task automatic frame(input int n, input bit pad);
		int i;
		for (i = 0; i < 7; i++) begin
			fr = 8'($urandom);
			if (i < n || pad) expQ.push_back({3'(i), (i < n) ? fr : 8'h00});
			if (i < n) push(fr, i == 0);
		end
	endtask
	task automatic drain(input string name);
		int k;
		ohValid = 1'b0;
		for (k = 0; k < 4000 && (expQ.size() != 0 || frameActive !== 1'b0); k++)
			@(negedge mclk);
		if (k == 4000) begin
			fail("drain timeout");
			end_sim();
		end
		repeat (20) @(negedge mclk);
		$display("test %s done", name);
	endtask
	// ==========================================
	// Main sequence
	// ==========================================
	initial begin
		int k;
		int edges;
		logic last;
		seedTmp = $urandom(44541);
		repeat (6) @(negedge mclk);
		rst_b = 1'b1;
		// Idle: clock runs, data low, stray byte dropped
		push(8'h5a, 1'b0);
		ohValid = 1'b0;
		edges = 0;
		last = ohClk;
		for (k = 0; k < 160; k++) begin
			@(negedge mclk);
			edges += (ohClk !== last);
			last = ohClk;
			checks++;
			if (ohData !== 1'b0 || frameActive !== 1'b0) fail("idle output active");
		end
		checks++;
		if (edges != 40) fail("overhead clock not free running");
		$display("test idle done");
		// Three back-to-back frames, enough for the buffer to refuse
		repeat (3) frame(7, 1'b0);
		drain("fill");
		checks++;
		if (fullSeen == 0) fail("buffer never refused");
		// Empty buffer mid-frame
		frame(2, 1'b1);
		drain("underrun");
		checks++;
		if (abortSeen != 1) fail("no underrun pulse");
		// Fresh first byte mid-frame restarts the sequence
		frame(3, 1'b0);
		frame(7, 1'b0);
		drain("resync");
		checks++;
		if (restartSeen != 1) fail("no resync pulse");
		end_sim();
	end
endmodule
bind e3_rx_overhead_serial_out oh_port_properties CHK (.mclk(mclk), .rst_b(rst_b),
	.overheadBitClockOut(overheadBitClockOut), .rxOverheadSerialOut(rxOverheadSerialOut),
	.overheadFrameMarker(overheadFrameMarker), .frameActive(frameActive),
	.underrun(underrun), .resync(resync));
`default_nettype wire

// ==== bench/oh_port_properties.sv ====
// Purpose: Port checks for the overhead serial output
// Assumes: Sees only top module ports, one clock domain
// Notes:   Bound from the bench top file
`timescale 1ns/1ps
`default_nettype none
module oh_port_properties (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic overheadBitClockOut,
	input wire logic rxOverheadSerialOut,
	input wire logic overheadFrameMarker,
	input wire logic frameActive,
	input wire logic underrun,
	input wire logic resync
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	logic [8:0] sinceMark;
	// ==========================================
	// Helpers
	// ==========================================
	// Cycles since the marker rose
	always_ff @(posedge mclk) begin
		if (!rst_b || $rose(overheadFrameMarker))
			sinceMark <= 9'h000;
		else if (sinceMark != 9'h1ff)
			sinceMark <= sinceMark + 9'h001;
	end
	sequence quietThree;
		$stable(overheadBitClockOut) [*3];
	endsequence
	sequence markHeld;
		overheadFrameMarker [*8] ##1 !overheadFrameMarker;
	endsequence
	// ==========================================
	// Assertions
	// ==========================================
	clk_period_a: assert property (
		$changed(overheadBitClockOut) |=> quietThree ##1 $changed(overheadBitClockOut))
		else $error("overhead clock period wrong");
	data_edge_a: assert property (
		$changed(rxOverheadSerialOut) |-> $fell(overheadBitClockOut))
		else $error("data moved off the falling edge");
	marker_edge_a: assert property (
		$changed(overheadFrameMarker) |-> $fell(overheadBitClockOut))
		else $error("marker moved off the falling edge");
	marker_width_a: assert property ($rose(overheadFrameMarker) |-> markHeld)
		else $error("marker not one period wide");
	frame_start_a: assert property ($rose(frameActive) |-> $rose(overheadFrameMarker))
		else $error("frame began without marker");
	frame_length_a: assert property (
		frameActive && !resync && !$rose(overheadFrameMarker) |-> sinceMark <= 9'h1bf)
		else $error("frame longer than 56 bits");
	abort_pulse_a: assert property (
		underrun |-> $fell(overheadBitClockOut) ##1 !underrun)
		else $error("underrun pulse misplaced");
	resync_pulse_a: assert property (
		resync |-> $rose(overheadFrameMarker) ##1 !resync)
		else $error("restart without marker");
endmodule
`default_nettype wire

// ==== bench/oh_terminal_model.sv ====
// Purpose: Terminal equipment recovering overhead bytes
// Assumes: Samples on the overhead clock rising edge
// Notes:   Reports each completed byte and its position
`timescale 1ns/1ps
`default_nettype none
module oh_terminal_model (
	input  wire logic       ohClk,
	input  wire logic       ohData,
	input  wire logic       ohMark,
	output var  logic [7:0] byteData,
	output var  logic [2:0] byteNum,
	output var  logic       byteTick
);
	logic [6:0] edgeCnt;
	logic [7:0] shift;
	initial begin
		edgeCnt = 7'h40;
		byteTick = 1'b0;
	end
	// Count rising edges since marker, shift in bits
	always @(posedge ohClk) begin
		if (ohMark)
			edgeCnt = 7'h00;
		else if (edgeCnt != 7'h40)
			edgeCnt = edgeCnt + 7'h01;
		shift = {shift[6:0], ohData};
		if (edgeCnt < 7'h38 && edgeCnt[2:0] == 3'h7) begin
			byteData = shift;
			byteNum = edgeCnt[5:3];
			byteTick = ~byteTick;
		end
	end
endmodule
`default_nettype wire

// ==== logic/e3_oh_map.vh ====
// Purpose: Shared constants for the received E3 overhead serial output port
// Assumes: Included by bare name from every design file that needs it
// Notes:   Definitions only; guarded against double inclusion
`ifndef E3_OH_MAP_VH
`define E3_OH_MAP_VH

// ==========================================================================
// Frame structure
// ==========================================================================
// Bytes in a received frame, and the overhead bytes among them
`define FRAME_BYTES      10'd537
`define OH_BYTES         3'd7
// Overhead bits sent per frame (seven bytes of eight)
`define OH_BITS          6'd56
`define OH_BIT_IDX_W     6

// ==========================================================================
// Staging FIFO word layout
// ==========================================================================
`define OH_WORD_W        9
`define OH_BYTE_MSB      7
`define OH_BYTE_LSB      0
`define OH_FIRST_POS     8
`define OH_FIFO_DEPTH    16
`define OH_FIFO_ADDR_W   4

// ==========================================================================
// Timing
// ==========================================================================
// System clock period and overhead bit clock period, in ns
`define MCLK_PERIOD_NS   20
`define OH_CLK_PERIOD_NS 160
// System clock cycles per half period of the overhead clock
`define OH_HALF_CYCLES   ((`OH_CLK_PERIOD_NS / `MCLK_PERIOD_NS) / 2)
`define OH_HALF_CNT_W    2

// ==========================================================================
// Serializer states (one-hot)
// ==========================================================================
`define ST_IDLE          2'b01
`define ST_SEND          2'b10

`endif

// ==== logic/e3_rx_overhead_serial_out.v ====
// Purpose: Serial output of the seven received E3 overhead bytes per frame
// Assumes: Framer pushes overhead bytes in order, first byte flagged
// Notes:   Overhead clock divided from mclk; data moves on its falling edge
`timescale 1ns/1ps
`default_nettype none
`include "e3_oh_map.vh"

module e3_rx_overhead_serial_out (
	input  wire       mclk,
	input  wire       rst_b,
	input  wire [7:0] ohByte,
	input  wire       ohFirst,
	input  wire       ohValid,
	output wire       ohReady,
	output reg        overheadBitClockOut,
	output reg        rxOverheadSerialOut,
	output reg        overheadFrameMarker,
	output reg        frameActive,
	output reg        underrun,
	output reg        resync
);

	// ======================================================================
	// Helpers
	// ======================================================================
	// True when the bit index sits on a byte boundary
	function startsByte;
		input [`OH_BIT_IDX_W-1:0] idx;
		begin
			startsByte = (idx[2:0] == 3'h0);
		end
	endfunction

	// True when every overhead bit of the frame has been driven
	function frameDone;
		input [`OH_BIT_IDX_W-1:0] idx;
		begin
			frameDone = (idx == `OH_BITS);
		end
	endfunction

	// ======================================================================
	// Declarations
	// ======================================================================
	// Last half-period count, cut to the counter width on purpose
	localparam integer              HALF_LAST_N = `OH_HALF_CYCLES - 1;
	localparam [`OH_HALF_CNT_W-1:0] HALF_LAST   = HALF_LAST_N[`OH_HALF_CNT_W-1:0];
	localparam [1:0] ST_IDLE = `ST_IDLE;
	localparam [1:0] ST_SEND = `ST_SEND;

	reg  [`OH_HALF_CNT_W-1:0] halfCnt;
	reg  [1:0]                state;
	reg  [`OH_BIT_IDX_W-1:0]  bitIdx;
	reg  [7:0]                shiftReg;
	wire                      halfEnd;
	wire                      fallEdge;
	wire [`OH_WORD_W-1:0]     pushWord;
	wire [`OH_WORD_W-1:0]     headWord;
	wire                      headValid;
	wire                      headFirst;
	wire [7:0]                headByte;
	reg                       popReady;

	// ======================================================================
	// Staging FIFO
	// ======================================================================
	// Byte and first-of-frame flag travel together
	assign pushWord = {ohFirst, ohByte};

	oh_byte_fifo #(
		.WIDTH  (`OH_WORD_W),
		.DEPTH  (`OH_FIFO_DEPTH),
		.ADDR_W (`OH_FIFO_ADDR_W)
	) u_fifo (
		.mclk     (mclk),
		.rst_b    (rst_b),
		.inData   (pushWord),
		.inValid  (ohValid),
		.inReady  (ohReady),
		.outData  (headWord),
		.outValid (headValid),
		.outReady (popReady)
	);

	assign headFirst = headWord[`OH_FIRST_POS];
	assign headByte  = headWord[`OH_BYTE_MSB:`OH_BYTE_LSB];

	// ======================================================================
	// Overhead bit clock
	// ======================================================================
	// Half-period counter; runs free from reset release
	assign halfEnd  = (halfCnt == HALF_LAST);
	// Clock is about to go low: the only moment data may move
	assign fallEdge = halfEnd && overheadBitClockOut;

	// Divider with no gate and no enable
	always @(posedge mclk) begin
		if (!rst_b) begin
			halfCnt             <= {`OH_HALF_CNT_W{1'b0}};
			overheadBitClockOut <= 1'b0;
		end else begin
			if (halfEnd) begin
				halfCnt             <= {`OH_HALF_CNT_W{1'b0}};
				overheadBitClockOut <= ~overheadBitClockOut;
			end else begin
				halfCnt <= halfCnt + {{(`OH_HALF_CNT_W-1){1'b0}}, 1'b1};
			end
		end
	end

	// ======================================================================
	// FIFO pop decision
	// ======================================================================
	// Pop at a falling edge when a new byte is due
	always @* begin
		popReady = 1'b0;
		if (fallEdge) begin
			case (state)
				ST_IDLE: begin
					popReady = 1'b1;
				end
				ST_SEND: begin
					popReady = startsByte(bitIdx);
				end
				default: begin
					popReady = 1'b0;
				end
			endcase
		end
	end

	// ======================================================================
	// Serializer
	// ======================================================================
	// Bytes go out MSB first; index counts bits already driven
	always @(posedge mclk) begin
		if (!rst_b) begin
			state               <= ST_IDLE;
			bitIdx              <= {`OH_BIT_IDX_W{1'b0}};
			shiftReg            <= 8'h00;
			rxOverheadSerialOut <= 1'b0;
			overheadFrameMarker <= 1'b0;
			frameActive         <= 1'b0;
			underrun            <= 1'b0;
			resync              <= 1'b0;
		end else begin
			underrun <= 1'b0;
			resync   <= 1'b0;
			if (fallEdge) begin
				// Marker lasts exactly one overhead period
				overheadFrameMarker <= 1'b0;
				case (state)
					ST_IDLE: begin
						if (headValid && headFirst) begin
							// FA1 bit 7 with the marker
							rxOverheadSerialOut <= headByte[7];
							shiftReg            <= {headByte[6:0], 1'b0};
							overheadFrameMarker <= 1'b1;
							bitIdx              <= {{(`OH_BIT_IDX_W-1){1'b0}}, 1'b1};
							frameActive         <= 1'b1;
							state               <= ST_SEND;
						end else begin
							// Stray bytes outside a frame are dropped
							rxOverheadSerialOut <= 1'b0;
						end
					end
					ST_SEND: begin
						if (!startsByte(bitIdx)) begin
							// Next bit of the current byte
							rxOverheadSerialOut <= shiftReg[7];
							shiftReg            <= {shiftReg[6:0], 1'b0};
							bitIdx              <= bitIdx + {{(`OH_BIT_IDX_W-1){1'b0}}, 1'b1};
						end else if (headValid && (headFirst || !frameDone(bitIdx))) begin
							// Load the next byte; a flagged byte restarts the frame
							rxOverheadSerialOut <= headByte[7];
							shiftReg            <= {headByte[6:0], 1'b0};
							if (headFirst) begin
								overheadFrameMarker <= 1'b1;
								bitIdx              <= {{(`OH_BIT_IDX_W-1){1'b0}}, 1'b1};
								resync              <= !frameDone(bitIdx);
							end else begin
								bitIdx <= bitIdx + {{(`OH_BIT_IDX_W-1){1'b0}}, 1'b1};
							end
						end else begin
							// Frame over, or data missing mid-frame
							underrun            <= !frameDone(bitIdx);
							rxOverheadSerialOut <= 1'b0;
							bitIdx              <= {`OH_BIT_IDX_W{1'b0}};
							frameActive         <= 1'b0;
							state               <= ST_IDLE;
						end
					end
					default: begin
						state       <= ST_IDLE;
						bitIdx      <= {`OH_BIT_IDX_W{1'b0}};
						frameActive <= 1'b0;
					end
				endcase
			end
		end
	end

endmodule

`default_nettype wire

// ==== logic/oh_byte_fifo.v ====
// Purpose: Small synchronous FIFO staging overhead bytes ahead of the serializer
// Assumes: Single clock, synchronous active-low reset
// Notes:   Valid/ready on both sides; simultaneous push and pop only when neither full nor empty
`timescale 1ns/1ps
`default_nettype none

module oh_byte_fifo #(
	parameter WIDTH  = 9,
	parameter DEPTH  = 16,
	parameter ADDR_W = 4
) (
	input  wire             mclk,
	input  wire             rst_b,
	input  wire [WIDTH-1:0] inData,
	input  wire             inValid,
	output wire             inReady,
	output wire [WIDTH-1:0] outData,
	output wire             outValid,
	input  wire             outReady
);

	// ======================================================================
	// Storage and pointers
	// ======================================================================
	reg  [WIDTH-1:0]  mem [0:DEPTH-1];
	reg  [ADDR_W-1:0] wrPtr;
	reg  [ADDR_W-1:0] rdPtr;
	reg  [ADDR_W:0]   fill;
	wire              push;
	wire              pop;

	// Honest full and empty from the fill count
	assign inReady  = (fill != DEPTH[ADDR_W:0]);
	assign outValid = (fill != {(ADDR_W+1){1'b0}});
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;
	assign outData  = mem[rdPtr];

	// Write port
	always @(posedge mclk) begin
		if (push) begin
			mem[wrPtr] <= inData;
		end
	end

	// Pointer and fill bookkeeping
	always @(posedge mclk) begin
		if (!rst_b) begin
			wrPtr <= {ADDR_W{1'b0}};
			rdPtr <= {ADDR_W{1'b0}};
			fill  <= {(ADDR_W+1){1'b0}};
		end else begin
			if (push) begin
				wrPtr <= wrPtr + {{(ADDR_W-1){1'b0}}, 1'b1};
			end
			if (pop) begin
				rdPtr <= rdPtr + {{(ADDR_W-1){1'b0}}, 1'b1};
			end
			if (push && !pop) begin
				fill <= fill + {{ADDR_W{1'b0}}, 1'b1};
			end else if (pop && !push) begin
				fill <= fill - {{ADDR_W{1'b0}}, 1'b1};
			end
		end
	end

endmodule

`default_nettype wire
